/* hdl/eat_pkg.sv */
// Shared types, cost tables and timing constants for the cycle-timing sequencer
package eat_pkg;

   // Clocks in one bus cycle without wait states
   localparam int BUS_CLKS = 4;

   // Addressing mode codes, used as table index
   typedef logic [3:0] eat_mode_t;
   localparam eat_mode_t MODE_DREG = 4'h0; // data_register_operand direct
   localparam eat_mode_t MODE_AREG = 4'h1; // address_register_operand direct
   localparam eat_mode_t MODE_IND = 4'h2;  // Register indirect
   localparam eat_mode_t MODE_PINC = 4'h3; // Indirect, postincrement
   localparam eat_mode_t MODE_PDEC = 4'h4; // Indirect, predecrement
   localparam eat_mode_t MODE_DISP = 4'h5; // Indirect, 16-bit displacement
   localparam eat_mode_t MODE_IDX = 4'h6;  // Indirect, index_register_operand
   localparam eat_mode_t MODE_ABSW = 4'h7; // Absolute short
   localparam eat_mode_t MODE_ABSL = 4'h8; // Absolute long
   localparam eat_mode_t MODE_PCD = 4'h9;  // Program counter, displacement
   localparam eat_mode_t MODE_PCX = 4'hA;  // Program counter, index
   localparam eat_mode_t MODE_IMM = 4'hB;  // Immediate
   localparam int NUM_MODES = 12;

   // Kind of timed operation
   typedef enum logic [1:0] {
      OP_EA_FETCH = 2'h0,
      OP_EA_NOFETCH = 2'h1,
      OP_MOVE = 2'h2
   } eat_op_e;

   // Request: one address computation or one byte/word move
   typedef struct packed {
      eat_op_e op;
      logic long_sz;
      eat_mode_t src;
      eat_mode_t dst;
   } eat_req_s;

   // Cost entry: total clocks, reads, writes, combination allowed
   typedef struct packed {
      logic [5:0] clk;
      logic [2:0] rd;
      logic wr;
      logic ok;
   } eat_cost_s;

   // Result of one run, clocks include wait states
   typedef struct packed {
      logic [15:0] clocks;
      logic [2:0] rd;
      logic wr;
      logic err;
   } eat_res_s;

   localparam eat_cost_s COST_NONE = '{6'h00, 3'h0, 1'h0, 1'h1};
   localparam eat_cost_s COST_BAD = '{6'h00, 3'h0, 1'h0, 1'h0};
   // Opcode word fetch of a move
   localparam eat_cost_s COST_OPCODE = '{6'h04, 3'h1, 1'h0, 1'h1};

   localparam eat_cost_s EA_FETCH_BW [NUM_MODES] = '{
      COST_NONE, COST_NONE,
      '{6'h04, 3'h1, 1'h0, 1'h1}, '{6'h04, 3'h1, 1'h0, 1'h1},
      '{6'h06, 3'h1, 1'h0, 1'h1}, '{6'h08, 3'h2, 1'h0, 1'h1},
      '{6'h0A, 3'h2, 1'h0, 1'h1}, '{6'h08, 3'h2, 1'h0, 1'h1},
      '{6'h0C, 3'h3, 1'h0, 1'h1}, '{6'h08, 3'h2, 1'h0, 1'h1},
      '{6'h0A, 3'h2, 1'h0, 1'h1}, '{6'h04, 3'h1, 1'h0, 1'h1}};

   localparam eat_cost_s EA_FETCH_L [NUM_MODES] = '{
      COST_NONE, COST_NONE,
      '{6'h08, 3'h2, 1'h0, 1'h1}, '{6'h08, 3'h2, 1'h0, 1'h1},
      '{6'h0A, 3'h2, 1'h0, 1'h1}, '{6'h0C, 3'h3, 1'h0, 1'h1},
      '{6'h0E, 3'h3, 1'h0, 1'h1}, '{6'h0C, 3'h3, 1'h0, 1'h1},
      '{6'h10, 3'h4, 1'h0, 1'h1}, '{6'h0C, 3'h3, 1'h0, 1'h1},
      '{6'h0E, 3'h3, 1'h0, 1'h1}, '{6'h08, 3'h2, 1'h0, 1'h1}};

   localparam eat_cost_s EA_NOFETCH_BW [NUM_MODES] = '{
      COST_NONE, COST_NONE,
      '{6'h02, 3'h0, 1'h0, 1'h1}, '{6'h04, 3'h0, 1'h0, 1'h1},
      '{6'h04, 3'h0, 1'h0, 1'h1}, '{6'h04, 3'h0, 1'h0, 1'h1},
      '{6'h08, 3'h1, 1'h0, 1'h1}, '{6'h04, 3'h1, 1'h0, 1'h1},
      '{6'h08, 3'h2, 1'h0, 1'h1}, COST_BAD, COST_BAD, COST_BAD};

   localparam eat_cost_s EA_NOFETCH_L [NUM_MODES] = '{
      COST_NONE, COST_NONE,
      '{6'h02, 3'h0, 1'h0, 1'h1}, '{6'h04, 3'h0, 1'h0, 1'h1},
      '{6'h04, 3'h0, 1'h0, 1'h1}, '{6'h04, 3'h1, 1'h0, 1'h1},
      '{6'h08, 3'h1, 1'h0, 1'h1}, '{6'h04, 3'h1, 1'h0, 1'h1},
      '{6'h08, 3'h2, 1'h0, 1'h1}, COST_BAD, COST_BAD, COST_BAD};

   // Destination share of a byte/word move: extension reads plus the store
   localparam eat_cost_s MOVE_DST [NUM_MODES] = '{
      COST_NONE, COST_NONE,
      '{6'h04, 3'h0, 1'h1, 1'h1}, '{6'h04, 3'h0, 1'h1, 1'h1},
      '{6'h04, 3'h0, 1'h1, 1'h1}, '{6'h08, 3'h1, 1'h1, 1'h1},
      '{6'h0A, 3'h1, 1'h1, 1'h1}, '{6'h08, 3'h1, 1'h1, 1'h1},
      '{6'h0C, 3'h2, 1'h1, 1'h1}, COST_BAD, COST_BAD, COST_BAD};

   // Sequencer states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_READ = 5'h02,
      ST_INT = 5'h04,
      ST_WRITE = 5'h08,
      ST_DONE = 5'h10
   } eat_state_e;

   // Reset value of the clock counts, and last phase of a bus cycle
   localparam logic [15:0] CLOCKS_RST = 16'h0000;
   localparam logic [1:0] PHASE_LAST = 2'h3;

endpackage

/* hdl/eat_core.sv */
// Bus-cycle sequencer that spends the documented clocks for address and move timing
`timescale 1ns/1ps

module eat_core
   import eat_pkg::*;
(
   input wire logic clk, // 250 MHz core clock
   input wire logic resetn, // Asynchronous reset, active low
   input wire logic req_valid, // Request offered
   output logic req_ready, // Sequencer can take a request
   input wire eat_req_s req, // Operation, size and modes
   output logic bus_rd, // Read bus cycle in progress
   output logic bus_wr, // Write bus cycle in progress
   input wire logic mem_ack, // Memory acknowledge, asynchronous
   output logic busy, // A run is in progress
   output logic done, // One-cycle pulse at end of run
   output eat_res_s res // Result, valid from done until next accept
);

   // State and counters
   eat_state_e state_q, state_d; // Sequencer state
   logic [2:0] rd_left_q; // Read cycles still to run
   logic [5:0] idle_left_q; // Internal clocks still to spend
   logic wr_left_q; // Write cycle still to run
   logic [1:0] phase_q; // Clock within the current bus cycle
   logic [15:0] tot_q; // Clocks spent so far in this run
   logic [15:0] waits_q; // Wait states seen in this run
   eat_cost_s plan_q; // Cost planned at accept
   eat_op_e op_q; // Operation of the running request
   logic err_q; // Request was not a timed combination
   logic ack_meta_q; // Acknowledge synchroniser, first stage
   logic ack_q; // Acknowledge synchroniser, second stage

   // Table lookups; unknown codes fall back to index zero and are refused
   logic src_ok, dst_ok; // Mode codes within the table
   eat_mode_t src_i, dst_i; // Safe table indexes
   eat_cost_s ea_cost; // Cost of an address computation
   eat_cost_s src_cost; // Source share of a move
   eat_cost_s dst_cost; // Destination share of a move
   eat_cost_s mv_cost; // Whole move
   eat_cost_s cost; // Selected cost
   logic [3:0] bus_cycles; // Reads plus writes
   logic [5:0] idle_clks; // Clocks with no bus cycle
   logic accept; // Request taken this cycle
   logic in_bus; // A bus cycle is running
   logic cyc_end; // Last clock of a bus cycle
   logic wait_clk; // Clock added by slow memory

   assign src_ok = (req.src <= MODE_IMM);
   assign dst_ok = (req.dst <= MODE_IMM);
   assign src_i = src_ok ? req.src : MODE_DREG;
   assign dst_i = dst_ok ? req.dst : MODE_DREG;

   // Index register width is not an input here, so it cannot alter timing
   // Fetch tables include extension words and the operand read
   // Register direct entries are zero in every table
   // Entries per mode and size
   // Further entries per mode and size
   assign ea_cost = (req.op == OP_EA_FETCH) ?
      (req.long_sz ? EA_FETCH_L[src_i] : EA_FETCH_BW[src_i]) :
      (req.long_sz ? EA_NOFETCH_L[src_i] : EA_NOFETCH_BW[src_i]);

   // Move = opcode fetch + source fetch + destination share
   assign src_cost = EA_FETCH_BW[src_i];
   assign dst_cost = MOVE_DST[dst_i];
   // Register and indirect cases come out of this sum
   // Displacement and absolute destinations likewise
   assign mv_cost.clk = 6'(COST_OPCODE.clk + src_cost.clk + dst_cost.clk);
   assign mv_cost.rd = 3'(COST_OPCODE.rd + src_cost.rd + dst_cost.rd);
   assign mv_cost.wr = dst_cost.wr;
   // Long moves are outside this sequencer and are refused
   // A source code past the table indexes as a register, so it must be refused here too
   assign mv_cost.ok = src_cost.ok & src_ok & dst_cost.ok & dst_ok & ~req.long_sz;

   // Select by operation; a reserved operation code is refused
   always_comb begin
      cost = COST_BAD;
      if (req.op == OP_MOVE) begin
         cost = mv_cost;
      end else if (req.op != OP_MOVE && req.op[1] == 1'b0) begin
         cost = ea_cost;
         cost.ok = ea_cost.ok & src_ok;
      end
   end

   // Internal clocks are what the total leaves after the bus cycles
   assign bus_cycles = 4'({1'b0, cost.rd} + {3'h0, cost.wr});
   assign idle_clks = 6'(cost.clk - 6'(bus_cycles * BUS_CLKS));

   // Handshake and bus qualifiers
   assign req_ready = (state_q == ST_IDLE);
   assign accept = req_valid & req_ready;
   assign in_bus = (state_q == ST_READ) || (state_q == ST_WRITE);
   // A cycle ends at its fourth clock, or later if memory is slow
   assign cyc_end = in_bus && (phase_q == PHASE_LAST) && ack_q;
   // Each clock held at the last phase is one wait state
   assign wait_clk = in_bus && (phase_q == PHASE_LAST) && !ack_q;

   // Reads first, then internal clocks, then the store
   function automatic eat_state_e pick(input logic [2:0] r, input logic [5:0] i,
                                       input logic w);
      eat_state_e s;
      s = ST_DONE;
      if (r != 3'h0) begin
         s = ST_READ;
      end else if (i != 6'h00) begin
         s = ST_INT;
      end else if (w) begin
         s = ST_WRITE;
      end
      return s;
   endfunction

   // Next state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (accept) begin
               // A refused combination ends at once with err set
               state_d = cost.ok ? pick(cost.rd, idle_clks, cost.wr) : ST_DONE;
            end
         end
         ST_READ: begin
            if (cyc_end) begin
               state_d = pick(3'(rd_left_q - 3'h1), idle_left_q, wr_left_q);
            end
         end
         ST_INT: begin
            if (idle_left_q == 6'h01) begin
               state_d = pick(3'h0, 6'h00, wr_left_q);
            end
         end
         ST_WRITE: begin
            if (cyc_end) begin
               state_d = ST_DONE;
            end
         end
         ST_DONE: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Acknowledge comes from another timing domain; two flops before use
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ack_meta_q <= 1'b0;
         ack_q <= 1'b0;
      end else begin
         ack_meta_q <= mem_ack;
         ack_q <= ack_meta_q;
      end
   end

   // Plan latched at accept
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         plan_q <= COST_NONE;
         op_q <= OP_EA_FETCH;
         err_q <= 1'b0;
      end else if (accept) begin
         // A refused request reports no bus cycles, whatever the tables summed to
         plan_q <= cost.ok ? cost : COST_BAD;
         op_q <= req.op;
         err_q <= ~cost.ok;
      end
   end

   // Reads left; counts down at the end of each read cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_left_q <= 3'h0;
      end else if (accept) begin
         rd_left_q <= cost.ok ? cost.rd : 3'h0;
      end else if (cyc_end && state_q == ST_READ) begin
         rd_left_q <= 3'(rd_left_q - 3'h1);
      end
   end

   // Internal clocks left; the bus stays quiet meanwhile
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         idle_left_q <= 6'h00;
      end else if (accept) begin
         idle_left_q <= cost.ok ? idle_clks : 6'h00;
      end else if (state_q == ST_INT) begin
         idle_left_q <= 6'(idle_left_q - 6'h01);
      end
   end

   // Store pending; only moves ever plan one
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_left_q <= 1'b0;
      end else if (accept) begin
         wr_left_q <= cost.ok & cost.wr & (req.op == OP_MOVE);
      end else if (cyc_end && state_q == ST_WRITE) begin
         wr_left_q <= 1'b0;
      end
   end

   // Bus phase: counts 0..3 and holds at 3 until acknowledged
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         phase_q <= 2'h0;
      end else if (!in_bus || cyc_end) begin
         phase_q <= 2'h0;
      end else if (phase_q != PHASE_LAST) begin
         phase_q <= 2'(phase_q + 2'h1);
      end
   end

   // Clock total of the run, so wait states land in it one for one
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tot_q <= CLOCKS_RST;
         waits_q <= CLOCKS_RST;
      end else if (accept) begin
         tot_q <= CLOCKS_RST;
         waits_q <= CLOCKS_RST;
      end else if (state_q != ST_IDLE && state_q != ST_DONE) begin
         tot_q <= 16'(tot_q + 16'h0001);
         waits_q <= 16'(waits_q + {15'h0000, wait_clk});
      end
   end

   // Outputs, decoded from the state flops; res straight from flops
   assign bus_rd = (state_q == ST_READ);
   assign bus_wr = (state_q == ST_WRITE);
   assign busy = !req_ready;
   assign done = (state_q == ST_DONE);
   assign res = '{tot_q, plan_q.rd, plan_q.wr, err_q};

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_read_start;
      $rose(bus_rd);
   endsequence

   sequence s_four_read;
      bus_rd[*4];
   endsequence

   property p_read_len;
      s_read_start |-> s_four_read;
   endproperty
   a_read_len: assert property (p_read_len)
      else $error("read cycle shorter than four");

   // Memory may stretch the store; without a wait the strobe drops after four clocks
   property p_write_len;
      $rose(bus_wr) |-> bus_wr[*4] ##1 (!bus_wr || !$past(ack_q));
   endproperty
   a_write_len: assert property (p_write_len)
      else $error("write cycle not four clocks");

   // A wait state keeps the strobe up and the phase parked at its last clock
   sequence s_wait_now;
      in_bus && (phase_q == PHASE_LAST) && !ack_q;
   endsequence

   property p_wait_hold;
      s_wait_now |=> in_bus && (phase_q == PHASE_LAST);
   endproperty
   a_wait_hold: assert property (p_wait_hold)
      else $error("wait state dropped the strobe");

   property p_total;
      done && !err_q |-> res.clocks == 16'(plan_q.clk + waits_q);
   endproperty
   a_total: assert property (p_total)
      else $error("clock total off plan plus waits");

   property p_idle_bus;
      state_q == ST_INT |-> !bus_rd && !bus_wr;
   endproperty
   a_idle_bus: assert property (p_idle_bus)
      else $error("bus active in internal clock");

   property p_ea_no_write;
      busy && op_q != OP_MOVE |-> !bus_wr;
   endproperty
   a_ea_no_write: assert property (p_ea_no_write)
      else $error("write during address calc");

   property p_reg_direct;
      accept && req.op != OP_MOVE && req.src <= MODE_AREG |=> done;
   endproperty
   a_reg_direct: assert property (p_reg_direct)
      else $error("register direct took clocks");

   // Without a wait state the single read ends at its fourth clock and done follows
   property p_reg_move;
      accept && req.op == OP_MOVE && !req.long_sz && req.src <= MODE_AREG
         && req.dst <= MODE_AREG |=> bus_rd[*4] ##1 (done || !$past(ack_q));
   endproperty
   a_reg_move: assert property (p_reg_move)
      else $error("register move not one read");

   property p_absl_move;
      accept && req.op == OP_MOVE && !req.long_sz && req.src == MODE_ABSL
         && req.dst == MODE_ABSL |=> plan_q.clk == 6'h1C && plan_q.rd == 3'h6 && plan_q.wr;
   endproperty
   a_absl_move: assert property (p_absl_move)
      else $error("absolute long move not 28");

   property p_ind_fetch;
      accept && req.op == OP_EA_FETCH && !req.long_sz && req.src == MODE_IND
         |=> plan_q.clk == 6'h04 && plan_q.rd == 3'h1;
   endproperty
   a_ind_fetch: assert property (p_ind_fetch)
      else $error("indirect fetch not four");

   property p_done_reads;
      done && !err_q && waits_q == 16'h0000 |-> res.clocks == {10'h000, plan_q.clk};
   endproperty
   a_done_reads: assert property (p_done_reads)
      else $error("no-wait total off table");

   // The store comes last: every read and internal clock is spent before it
   property p_write_last;
      bus_wr |-> rd_left_q == 3'h0 && idle_left_q == 6'h00;
   endproperty
   a_write_last: assert property (p_write_last)
      else $error("write before reads finished");

   // A refused request ends at once, reports no traffic and leaves the bus alone
   property p_refused;
      accept && !cost.ok |=> done && err_q && !bus_rd && !bus_wr
         && res.rd == 3'h0 && !res.wr;
   endproperty
   a_refused: assert property (p_refused)
      else $error("refused request used the bus");

endmodule

/* tb/eat_mem_model.sv */
// Behavioural memory that acknowledges the first bus cycle of each strobe episode after a chosen number of wait states
`timescale 1ns/1ps

module eat_mem_model (
   input wire logic clk, // Bus clock
   input wire logic bus_rd, // Read strobe from the sequencer
   input wire logic bus_wr, // Write strobe from the sequencer
   input wire logic [3:0] wait_n, // Wait states added to the first bus cycle of each strobe episode
   output logic mem_ack // Acknowledge, never outlives its strobe
);
   logic [1:0] prev_q = 2'h0; // Strobe kind seen at the last edge
   logic [7:0] cnt_q = 8'h00; // Edges since the present strobe kind began
   logic [7:0] age; // Age of the present strobe, zero when fresh

   // Count edges within one strobe episode; a change of kind restarts it
   always @(posedge clk) begin
      if ({bus_rd, bus_wr} == prev_q) begin
         cnt_q <= cnt_q + 8'h01;
      end else begin
         cnt_q <= 8'h01;
      end
      prev_q <= {bus_rd, bus_wr};
   end

   assign age = ({bus_rd, bus_wr} == prev_q) ? cnt_q : 8'h00;
   // Ack falls with the strobe, so a following cycle never sees a stale ack
   // Ack in the cycle's second clock is the latest that still gives four clocks through
   // the sequencer's two-flop synchroniser; each wait state delays it one clock more.
   // Back-to-back cycles of one kind keep the strobe up, so only the first is stretched.
   assign mem_ack = (bus_rd | bus_wr) && (age > {4'h0, wait_n});
endmodule

/* tb/tb.sv */
// Self-checking bench for the address and move timing sequencer
`timescale 1ns/1ps

module tb;
   import eat_pkg::*;

   logic clk = 1'b0; // 4 ns clock
   logic resetn = 1'b0; // Reset, active low
   logic req_valid = 1'b0; // Request offered
   eat_req_s req = '0; // Request fields
   logic [3:0] wait_n = 4'h0; // Wait states on the first bus cycle of each strobe episode
   logic req_ready, bus_rd, bus_wr, mem_ack, busy, done; // Handshake and bus
   eat_res_s res; // Result record
   logic [31:0] rng = 32'h55F2; // Xorshift state
   int n_errors = 0; // Mismatches
   int tests_run = 0; // Comparisons

   always #2 clk = ~clk;

   eat_core uut (.clk(clk), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
      .req(req), .bus_rd(bus_rd), .bus_wr(bus_wr), .mem_ack(mem_ack), .busy(busy),
      .done(done), .res(res));

   eat_mem_model u_mem (.clk(clk), .bus_rd(bus_rd), .bus_wr(bus_wr), .wait_n(wait_n),
      .mem_ack(mem_ack));

   // Xorshift step, fixed seed keeps runs repeatable
   function automatic logic [31:0] next_rand();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   // Zero-wait cost of a request, built from the timing tables
   function automatic eat_res_s expect_cost(eat_req_s r);
      int fc [12] = '{0, 0, 4, 4, 6, 8, 10, 8, 12, 8, 10, 4};
      int fr [12] = '{0, 0, 1, 1, 1, 2, 2, 2, 3, 2, 2, 1};
      int nc [9] = '{0, 0, 2, 4, 4, 4, 8, 4, 8};
      int nr [9] = '{0, 0, 0, 0, 0, 0, 1, 1, 2};
      int dc [9] = '{0, 0, 4, 4, 4, 8, 10, 8, 12};
      int dr [9] = '{0, 0, 0, 0, 0, 1, 1, 1, 2};
      logic mem_src;
      eat_res_s e;
      e = '0;
      mem_src = r.long_sz && (r.src > MODE_AREG);
      // Refused shapes finish at once with the error flag
      if (2'(r.op) == 2'h3 || r.src > MODE_IMM || (r.op == OP_EA_NOFETCH && r.src > MODE_ABSL)
          || (r.op == OP_MOVE && (r.long_sz || r.dst > MODE_ABSL))) begin
         e.err = 1'b1;
      end else if (r.op == OP_EA_FETCH) begin
         e.clocks = 16'(fc[r.src] + (mem_src ? 4 : 0));
         e.rd = 3'(fr[r.src] + (mem_src ? 1 : 0));
      end else if (r.op == OP_EA_NOFETCH) begin
         e.clocks = 16'(nc[r.src]);
         e.rd = 3'(nr[r.src] + ((r.long_sz && r.src == MODE_DISP) ? 1 : 0));
      end else begin
         // Opcode fetch, then source operand, then destination share
         e.clocks = 16'(4 + fc[r.src] + dc[r.dst]);
         e.rd = 3'(1 + fr[r.src] + dr[r.dst]);
         e.wr = (r.dst > MODE_AREG);
      end
      return e;
   endfunction

   task automatic check_res(eat_res_s got, eat_res_s exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected result at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic check_num(logic [15:0] got, logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected count at %0t: got %0d want %0d", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // One request from offer to done, tallying bus clocks on the way; called at a falling edge
   task automatic run(eat_req_s r, logic [3:0] w);
      eat_res_s exp;
      int n;
      int rd_clk;
      int wr_clk;
      logic saw_wr;
      logic bad;
      exp = expect_cost(r);
      exp.clocks = exp.clocks + 16'(int'(w) * (int'(exp.rd) + int'(exp.wr)));
      n = 0;
      rd_clk = 0;
      wr_clk = 0;
      saw_wr = 1'b0;
      bad = 1'b0;
      req = r;
      wait_n = w;
      req_valid = 1'b1;
      while (req_ready !== 1'b1) begin
         n++;
         if (n > 20) begin
            n_errors++;
            end_of_test();
         end
         @(negedge clk);
      end
      @(negedge clk);
      req_valid = 1'b0;
      n = 1;
      while (done !== 1'b1) begin
         rd_clk += (bus_rd === 1'b1);
         wr_clk += (bus_wr === 1'b1);
         // A read after the store, or a dropped handshake, is a fault
         bad |= (bus_rd === 1'b1 && saw_wr) || req_ready !== 1'b0 || busy !== 1'b1;
         saw_wr |= (bus_wr === 1'b1);
         @(negedge clk);
         n++;
         if (n > 300) begin
            n_errors++;
            end_of_test();
         end
      end
      check_num(16'(n), exp.clocks + 16'h0001);
      check_res(res, exp);
      check_num(16'(rd_clk), 16'((4 + w) * exp.rd));
      check_num(16'(wr_clk), 16'((4 + w) * exp.wr));
      check_num({11'h000, bad, bus_rd, bus_wr, busy, req_ready}, 16'h0002);
   endtask

   initial begin
      eat_req_s r;
      logic [31:0] x;
      eat_res_s e;
      r = '0;
      repeat (8) @(negedge clk);
      // Quiet outputs while held in reset
      check_res(res, '0);
      check_num({11'h000, req_ready, busy, done, bus_rd, bus_wr}, 16'h0010);
      resetn = 1'b1;
      // Every operation, size and mode pair, refused ones included
      for (int op = 0; op < 4; op++) begin
         for (int sz = 0; sz < 2; sz++) begin
            for (int s = 0; s < 16; s++) begin
               for (int d = 0; d < ((op == 2) ? 16 : 1); d++) begin
                  r.op = eat_op_e'(op[1:0]);
                  r.long_sz = sz[0];
                  r.src = eat_mode_t'(s);
                  r.dst = eat_mode_t'(d);
                  run(r, 4'h0);
               end
            end
         end
      end
      // Random requests; shapes with at most one read also get random wait states
      for (int i = 0; i < 300; i++) begin
         x = next_rand();
         r.op = eat_op_e'(x[1:0]);
         r.long_sz = x[2];
         r.src = x[6:3];
         r.dst = (r.op == OP_MOVE) ? x[10:7] : 4'h0;
         e = expect_cost(r);
         run(r, (e.rd <= 3'h1) ? {2'h0, x[12:11]} : 4'h0);
      end
      // Long stretch on a register-to-memory move
      r = '{OP_MOVE, 1'b0, MODE_DREG, MODE_PDEC};
      run(r, 4'h8);
      // Reset in the middle of the longest move, then a clean request
      req = '{OP_MOVE, 1'b0, MODE_ABSL, MODE_ABSL};
      req_valid = 1'b1;
      repeat (10) @(negedge clk);
      resetn = 1'b0;
      req_valid = 1'b0;
      @(negedge clk);
      check_num({11'h000, req_ready, busy, done, bus_rd, bus_wr}, 16'h0010);
      resetn = 1'b1;
      run(req, 4'h0);
      end_of_test();
   end
endmodule
